// >>> core/scc_capcom.sv
// scc_capcom: sixteen-channel capture/compare unit with two reloadable time bases
// assumes: register port on clk_i, pins and external count asynchronous
// Function
// - sixteen channels, one-cycle resolution, eight cycles when staggered
// - two independent 16-bit timers, each with a reload register
// - timer clock from prescaled system clock or upstream timer overflow
// - first timer may also count external input events
// - each channel picks either timer; channels 0-9 capture or compare, channels 10-15 compare only
// - ten channels own one pin, capture input or compare output
// - compare mode 0 raises a request on every match
// - compare mode 1 toggles the pin on every match
// - compare mode 2 raises at most one request per timer period
// - compare mode 3 sets pin on match, clears on timer overflow
// - double register mode lets two channels toggle one pin
// - single event option allows only one edge or pulse
// - capture latches the allocated timer on the selected pin event
// - each capture raises that channel's own request
// - capture edge is rising, falling or both per channel
// - compare channels are checked against their timer once per timer step
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module scc_capcom
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [5:0] adr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [scc_pkg::NPIN-1:0] cc_pin_i,
  output logic [scc_pkg::NPIN-1:0] cc_pin_o,
  output logic [scc_pkg::NPIN-1:0] cc_pin_oe_o,
  input wire logic ext_count_i,
  input wire logic upstream_timer_overflow_source_i,
  output logic [scc_pkg::NCH-1:0] irq_o
);
  scc_core_t r;
  scc_core_t n;
  logic [15:0] ta_cnt;
  logic [15:0] ta_rel;
  logic [15:0] tb_cnt;
  logic [15:0] tb_rel;
  logic ta_step;
  logic ta_ovf;
  logic tb_step;
  logic tb_ovf;
  logic ta_tick;
  logic tb_tick;
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] fall;
  logic [NCH-1:0][15:0] tv;
  logic [NCH-1:0] stp;
  logic [NCH-1:0] ov;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] hit;
  logic [3:0] sh_a;
  logic [3:0] sh_b;
  logic stag;
  logic [NCH-1:0] pair_hit;

  // prescaler tap: true when the low sh bits of the counter are zero
  function automatic logic presc_tick(input logic [9:0] cnt, input logic [3:0] sh);
    logic [9:0] m;
    m = ~(10'h3FF << sh);
    return (cnt & m) == 10'h0;
  endfunction

  // register write decode for a fixed address
  function automatic logic wr_at(input logic wr, input logic [5:0] adr, input logic [5:0] at);
    return wr && adr == at;
  endfunction

  // channel control decode: function and compare mode fields
  function automatic logic [1:0] fn_of(input logic [7:0] c);
    return c[CTL_FN +: 2];
  endfunction

  function automatic logic [1:0] md_of(input logic [7:0] c);
    return c[CTL_MD +: 2];
  endfunction

  // pin and external count synchronisers
  scc_sync_edge u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({ext_count_i, cc_pin_i}),
    .rise_o(rise),
    .fall_o(fall)
  );

  // count clock selection; staggered mode makes every prescaler tap eight times longer
  always_comb
  begin
    stag = r.tctl[TC_STAG];
    sh_a = {1'b0, r.tctl[TC_PS_A +: 3]} + (stag ? STAG_SHIFT : 4'h0);
    sh_b = {1'b0, r.tctl[TC_PS_B +: 3]} + (stag ? STAG_SHIFT : 4'h0);
    ta_tick = 1'b0;
    tb_tick = 1'b0;
    case (r.tctl[TC_SRC_A +: 2])
      SRC_PRE: ta_tick = presc_tick(r.pre, sh_a);
      SRC_UP: ta_tick = upstream_timer_overflow_source_i;
      SRC_EXT: ta_tick = rise[NPIN];
      default: ta_tick = 1'b0;
    endcase
    case (r.tctl[TC_SRC_B +: 2])
      SRC_PRE: tb_tick = presc_tick(r.pre, sh_b);
      SRC_UP: tb_tick = upstream_timer_overflow_source_i;
      default: tb_tick = 1'b0;
    endcase
    ta_tick = ta_tick && r.tctl[TC_RUN_A];
    tb_tick = tb_tick && r.tctl[TC_RUN_B];
  end

  // time base a
  scc_timer u_ta (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tick_i(ta_tick),
    .wr_cnt_i(wr_at(wr_i, adr_i, ADR_TA_CNT)),
    .wr_rel_i(wr_at(wr_i, adr_i, ADR_TA_REL)),
    .wdata_i(wdata_i),
    .cnt_o(ta_cnt),
    .rel_o(ta_rel),
    .step_o(ta_step),
    .ovf_o(ta_ovf)
  );

  // time base b
  scc_timer u_tb (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tick_i(tb_tick),
    .wr_cnt_i(wr_at(wr_i, adr_i, ADR_TB_CNT)),
    .wr_rel_i(wr_at(wr_i, adr_i, ADR_TB_REL)),
    .wdata_i(wdata_i),
    .cnt_o(tb_cnt),
    .rel_o(tb_rel),
    .step_o(tb_step),
    .ovf_o(tb_ovf)
  );

  // per-channel timer view and event detection
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      tv[i] = r.ctl[i][CTL_TSEL] ? tb_cnt : ta_cnt;
      stp[i] = r.ctl[i][CTL_TSEL] ? tb_step : ta_step;
      ov[i] = r.ctl[i][CTL_TSEL] ? tb_ovf : ta_ovf;
      cap_ev[i] = 1'b0;
      if (i < NPIN && r.ctl[i][CTL_FN +: 2] == FN_CAP)
      begin
        cap_ev[i] = (r.ctl[i][CTL_MD] && rise[i]) || (r.ctl[i][CTL_MD + 1] && fall[i]);
      end
      // a match is judged once per timer step, so a stalled timer cannot repeat it
      hit[i] = r.ctl[i][CTL_FN +: 2] == FN_CMP && stp[i] && tv[i] == r.val[i] && !r.spent[i];
      if (r.ctl[i][CTL_MD +: 2] == MD_IRQ1 || r.ctl[i][CTL_MD +: 2] == MD_SET)
      begin
        hit[i] = hit[i] && !r.done[i];
      end
    end
  end

  // partner match of the upper half seen at the lower channel's index
  assign pair_hit = hit >> (NCH / 2);

  // channel state, pins and register port
  always_comb
  begin
    n = r;
    n.irq = '0;
    n.pre = r.pre + 10'h1;
    for (int i = 0; i < NCH; i++)
    begin
      if (ov[i])
      begin
        n.done[i] = 1'b0;
      end
      if (hit[i])
      begin
        n.irq[i] = 1'b1;
        n.done[i] = 1'b1;
        if (r.ctl[i][CTL_SGL])
        begin
          n.spent[i] = 1'b1;
        end
      end
    end
    // pin actions: toggle, set on match, clear on overflow
    for (int p = 0; p < NPIN; p++)
    begin
      if (r.ctl[p][CTL_FN +: 2] == FN_CMP)
      begin
        if (r.ctl[p][CTL_MD +: 2] == MD_SET && ov[p])
        begin
          n.pin[p] = 1'b0;
        end
        if (hit[p] && r.ctl[p][CTL_MD +: 2] == MD_SET)
        begin
          n.pin[p] = 1'b1;
        end
        if ((hit[p] && md_of(r.ctl[p]) == MD_TOG) || (r.ctl[p][CTL_DBL] && pair_hit[p]))
        begin
          n.pin[p] = ~r.pin[p];
        end
      end
    end
    // software writes
    if (wr_i && adr_i == ADR_TCTL)
    begin
      n.tctl = wdata_i;
    end
    if (wr_i && adr_i[5:4] == BANK_VAL)
    begin
      n.val[adr_i[3:0]] = wdata_i;
    end
    if (wr_i && adr_i[5:4] == BANK_CTL)
    begin
      n.ctl[adr_i[3:0]] = wdata_i[7:0] & CTL_WMASK;
      // a match in the rewrite cycle still sets its flags
      n.spent[adr_i[3:0]] = hit[adr_i[3:0]] && r.ctl[adr_i[3:0]][CTL_SGL];
      n.done[adr_i[3:0]] = hit[adr_i[3:0]];
    end
    // captures override a same-cycle software write
    for (int i = 0; i < NPIN; i++)
    begin
      if (cap_ev[i])
      begin
        n.val[i] = tv[i];
        n.irq[i] = 1'b1;
      end
    end
    // read data, valid in the cycle after the strobe only
    n.rdata = 16'h0;
    if (rd_i)
    begin
      case (adr_i[5:4])
        2'h0:
        begin
          case (adr_i)
            ADR_TA_CNT: n.rdata = ta_cnt;
            ADR_TA_REL: n.rdata = ta_rel;
            ADR_TB_CNT: n.rdata = tb_cnt;
            ADR_TB_REL: n.rdata = tb_rel;
            ADR_TCTL: n.rdata = r.tctl;
            ADR_PINS: n.rdata = {6'h0, r.pin};
            default: n.rdata = 16'h0;
          endcase
        end
        BANK_VAL: n.rdata = r.val[adr_i[3:0]];
        BANK_CTL: n.rdata = {8'h0, r.ctl[adr_i[3:0]]};
        default: n.rdata = 16'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      r <= CORE_RST;
    else
      r <= n;
  end

  // outputs; only compare modes that drive a pin enable it
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      cc_pin_oe_o[p] = r.ctl[p][CTL_FN +: 2] == FN_CMP && r.ctl[p][CTL_MD];
    end
  end
  assign cc_pin_o = r.pin;
  assign irq_o = r.irq;
  assign rdata_o = r.rdata;

  AST_CAP_LATCH: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cap_ev[1] |=> r.val[1] == $past(tv[1]))
    else $error("capture did not latch timer");

  AST_CAP_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cap_ev[1] |=> irq_o[1])
    else $error("capture request missing");

  AST_CAP_EDGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.ctl[1][CTL_FN +: 2] == FN_CAP && r.ctl[1][CTL_MD +: 2] == 2'h1 && fall[1] && !rise[1] |-> !cap_ev[1])
    else $error("falling edge captured in rising-only mode");

  AST_CMP_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.ctl[0][CTL_FN +: 2] == FN_CMP && stp[0] && tv[0] == r.val[0] && !r.spent[0]
    && r.ctl[0][CTL_MD +: 2] == MD_IRQ |=> irq_o[0])
    else $error("mode 0 match gave no request");

  AST_CMP_TOG: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hit[0] && r.ctl[0][CTL_MD +: 2] == MD_TOG && !r.ctl[0][CTL_DBL] |=> cc_pin_o[0] != $past(cc_pin_o[0]))
    else $error("mode 1 pin did not toggle");

  AST_CMP_ONCE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hit[0] && r.ctl[0][CTL_MD +: 2] == MD_IRQ1 ##1 !ov[0] && $stable(r.ctl[0]) |-> !hit[0])
    else $error("mode 2 matched twice in one period");

  AST_CMP_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.ctl[0][CTL_FN +: 2] == FN_CMP && r.ctl[0][CTL_MD +: 2] == MD_SET && ov[0] && !hit[0] |=> !cc_pin_o[0])
    else $error("mode 3 pin not cleared on overflow");

  AST_CMP_DBL: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.ctl[0][CTL_FN +: 2] == FN_CMP && r.ctl[0][CTL_DBL] && hit[8] && !hit[0] |=> cc_pin_o[0] != $past(cc_pin_o[0]))
    else $error("partner match did not toggle shared pin");

  AST_CMP_SINGLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hit[0] && r.ctl[0][CTL_SGL] && !(wr_i && adr_i == {BANK_CTL, 4'h0}) |=> !hit[0] [*2])
    else $error("single event channel fired again");

  AST_CMP_SETPIN: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hit[0] && md_of(r.ctl[0]) == MD_SET && !pair_hit[0] |=> cc_pin_o[0])
    else $error("mode 3 pin not set on match");

  AST_CMP_TIMER: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.ctl[0][CTL_TSEL] && tb_cnt != r.val[0] |-> !hit[0])
    else $error("channel matched against the wrong time base");

  AST_PIN_OE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fn_of(r.ctl[0]) != FN_CMP |-> !cc_pin_oe_o[0])
    else $error("pin driven by a channel that is not comparing");

  AST_CAP_BOTH: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fn_of(r.ctl[1]) == FN_CAP && md_of(r.ctl[1]) == 2'h3 && (rise[1] || fall[1]) |-> cap_ev[1])
    else $error("edge missed in both-edges capture");

  AST_TICK_STAG: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.tctl[TC_STAG] && r.tctl[TC_SRC_A +: 2] == SRC_PRE && ta_tick |-> r.pre[2:0] == 3'h0)
    else $error("staggered tick off the eight-cycle grid");

  AST_TICK_UP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.tctl[TC_SRC_B +: 2] == SRC_UP && r.tctl[TC_RUN_B] && upstream_timer_overflow_source_i
    && !(wr_i && adr_i == ADR_TB_CNT) |=> tb_step)
    else $error("upstream tick did not step time base b");

  AST_TICK_EXT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.tctl[TC_SRC_A +: 2] == SRC_EXT && r.tctl[TC_RUN_A] && rise[NPIN]
    && !(wr_i && adr_i == ADR_TA_CNT) |=> ta_step)
    else $error("external event did not step time base a");
endmodule
`default_nettype wire

// >>> common/scc_pkg.sv
// scc_pkg: shared constants and state types of the sixteen-channel capture/compare unit
// assumes: one 25 MHz system clock, 6-bit word address register port, 16-bit data
package scc_pkg;
  localparam int NCH = 16;
  localparam int NPIN = 10;
  localparam int NSYNC = 11;
  // register address map: bank in adr[5:4], index in adr[3:0]
  localparam logic [5:0] ADR_TA_CNT = 6'h00;
  localparam logic [5:0] ADR_TA_REL = 6'h01;
  localparam logic [5:0] ADR_TB_CNT = 6'h02;
  localparam logic [5:0] ADR_TB_REL = 6'h03;
  localparam logic [5:0] ADR_TCTL = 6'h04;
  localparam logic [5:0] ADR_PINS = 6'h05;
  localparam logic [1:0] BANK_VAL = 2'h1;
  localparam logic [1:0] BANK_CTL = 2'h2;
  // timer control fields
  localparam int TC_PS_A = 0;
  localparam int TC_SRC_A = 3;
  localparam int TC_RUN_A = 5;
  localparam int TC_PS_B = 8;
  localparam int TC_SRC_B = 11;
  localparam int TC_RUN_B = 13;
  localparam int TC_STAG = 15;
  localparam logic [1:0] SRC_PRE = 2'h0;
  localparam logic [1:0] SRC_UP = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [3:0] STAG_SHIFT = 4'h3;
  // channel control fields
  localparam int CTL_FN = 0;
  localparam int CTL_MD = 2;
  localparam int CTL_TSEL = 4;
  localparam int CTL_SGL = 5;
  localparam int CTL_DBL = 6;
  localparam logic [7:0] CTL_WMASK = 8'h7F;
  localparam logic [1:0] FN_OFF = 2'h0;
  localparam logic [1:0] FN_CAP = 2'h1;
  localparam logic [1:0] FN_CMP = 2'h2;
  localparam logic [1:0] MD_IRQ = 2'h0;
  localparam logic [1:0] MD_TOG = 2'h1;
  localparam logic [1:0] MD_IRQ1 = 2'h2;
  localparam logic [1:0] MD_SET = 2'h3;
  localparam logic [15:0] TMR_MAX = 16'hFFFF;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rel;
    logic step;
    logic ovf;
  } scc_tmr_t;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
  } scc_sync_t;

  typedef struct packed {
    logic [NCH-1:0][15:0] val;
    logic [NCH-1:0][7:0] ctl;
    logic [NCH-1:0] done;
    logic [NCH-1:0] spent;
    logic [NPIN-1:0] pin;
    logic [NCH-1:0] irq;
    logic [15:0] rdata;
    logic [15:0] tctl;
    logic [9:0] pre;
  } scc_core_t;

  localparam scc_tmr_t TMR_RST = '0;
  localparam scc_sync_t SYNC_RST = '0;
  localparam scc_core_t CORE_RST = '0;
endpackage

// >>> core/scc_timer.sv
// scc_timer: one 16-bit time base with its reload register
// assumes: tick_i is a one-cycle count enable from the same clock
`timescale 1ns/100ps
`default_nettype none
module scc_timer
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic wr_cnt_i,
  input wire logic wr_rel_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] cnt_o,
  output logic [15:0] rel_o,
  output logic step_o,
  output logic ovf_o
);
  scc_tmr_t r;
  scc_tmr_t n;

  // count, reload on overflow, software write wins
  always_comb
  begin
    n = r;
    n.step = 1'b0;
    n.ovf = 1'b0;
    if (wr_cnt_i)
    begin
      n.cnt = wdata_i;
    end
    else if (tick_i)
    begin
      n.step = 1'b1;
      if (r.cnt == TMR_MAX)
      begin
        n.cnt = r.rel;
        n.ovf = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt + 16'h1;
      end
    end
    if (wr_rel_i)
    begin
      n.rel = wdata_i;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      r <= TMR_RST;
    else
      r <= n;
  end

  assign cnt_o = r.cnt;
  assign rel_o = r.rel;
  assign step_o = r.step;
  assign ovf_o = r.ovf;

  AST_TMR_RELOAD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick_i && !wr_cnt_i && r.cnt == TMR_MAX |=> r.ovf && r.cnt == $past(r.rel))
    else $error("timer did not reload on overflow");

  AST_TMR_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick_i && !wr_cnt_i && r.cnt != TMR_MAX |=> r.step && !r.ovf && r.cnt == $past(r.cnt) + 16'h1)
    else $error("timer did not advance by one");
endmodule
`default_nettype wire

// >>> core/scc_sync_edge.sv
// scc_sync_edge: two-flop synchroniser with edge detect for the pin inputs
// assumes: inputs are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module scc_sync_edge
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [NSYNC-1:0] d_i,
  output logic [NSYNC-1:0] rise_o,
  output logic [NSYNC-1:0] fall_o
);
  scc_sync_t r;
  scc_sync_t n;

  // shift chain; s1 is read only by s2
  always_comb
  begin
    n.s1 = d_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      r <= SYNC_RST;
    else
      r <= n;
  end

  assign rise_o = r.s2 & ~r.s3;
  assign fall_o = ~r.s2 & r.s3;
endmodule
`default_nettype wire

// >>> bench/scc_far_model.sv
// scc_far_model: channel pins, external count input and upstream timer overflow
// assumes: steered from tb_top through its tasks, all changes just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module scc_far_model
(
  input wire logic clk_i,
  output logic [9:0] pin_o,
  output logic ext_o,
  output logic up_o
);
  // idle levels from time zero
  initial
  begin
    pin_o = '0;
    ext_o = 1'b0;
    up_o = 1'b0;
  end
  // one high cycle is one upstream tick
  task automatic pulse_up();
    @(posedge clk_i) up_o <= 1'b1;
    @(posedge clk_i) up_o <= 1'b0;
  endtask
  // slow external event, four cycles high then four low
  task automatic pulse_ext();
    @(posedge clk_i) ext_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    ext_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // new pin level just after an edge
  task automatic set_pin(input int p, input logic v);
    @(posedge clk_i) pin_o[p] <= v;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// tb_top: self-checking bench of the capture/compare unit
// assumes: scc_capcom with its in-design assertions, far side from scc_far_model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import scc_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic [15:0] irqs; logic [15:0] pin; logic [15:0] oe;} scc_row_t;
  // compare modes, single event and timer choice: ctl, requests, pin, enable
  localparam scc_row_t ROWS [8] = '{'{8'h02, 16'h2, 16'h0, 16'h0}, '{8'h06, 16'h2, 16'h0, 16'h1},
    '{8'h0A, 16'h1, 16'h0, 16'h0}, '{8'h22, 16'h1, 16'h0, 16'h0}, '{8'h26, 16'h1, 16'h1, 16'h1},
    '{8'h26, 16'h1, 16'h0, 16'h1}, '{8'h0E, 16'h1, 16'h1, 16'h1}, '{8'h12, 16'h0, 16'h1, 16'h0}};
  logic clk_i, resetn_i, wr_i, rd_i, up, ext;
  logic [5:0] adr_i;
  logic [15:0] wdata_i, rdata_o, d, q;
  logic [NPIN-1:0] pin_o, oe_o, far_pin, pin_wire;
  logic [NCH-1:0] irq_o;
  int irq_cnt [NCH] = '{default: 0};
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int base;
  scc_capcom dut (.clk_i(clk_i), .resetn_i(resetn_i), .adr_i(adr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cc_pin_i(pin_wire), .cc_pin_o(pin_o), .cc_pin_oe_o(oe_o),
    .ext_count_i(ext), .upstream_timer_overflow_source_i(up), .irq_o(irq_o));
  scc_far_model far (.clk_i(clk_i), .pin_o(far_pin), .ext_o(ext), .up_o(up));
  // pin level: the unit wins where it drives
  assign pin_wire = (oe_o & pin_o) | (~oe_o & far_pin);
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // request pulse counters and hang limit
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    for (int i = 0; i < NCH; i++)
      if (irq_o[i] === 1'b1)
        irq_cnt[i] <= irq_cnt[i] + 1;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk_i);
    adr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk_i);
    adr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // main sequence
  initial
  begin
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    adr_i = '0;
    wdata_i = '0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(ADR_TA_CNT, d);
    check(d, 16'h0000);
    rd(ADR_TCTL, d);
    check(d, 16'h0000);
    rd(6'h3F, d);
    check(d, 16'h0000);
    check({6'h00, pin_o}, 16'h0000);
    check(irq_o, 16'h0000);
    wr({BANK_CTL, 4'hF}, 16'h0080);
    rd({BANK_CTL, 4'hF}, d);
    check(d, 16'h0000);
    // both timers on upstream ticks, a at 0x4F and b at 0x4D before each tick
    wr(ADR_TCTL, 16'h2828);
    foreach (ROWS[r])
    begin
      wr({BANK_VAL, 4'h0}, 16'h0050);
      wr({BANK_CTL, 4'h0}, {8'h00, ROWS[r].ctl});
      settle();
      base = irq_cnt[0];
      repeat (2)
      begin
        wr(ADR_TA_CNT, 16'h004F);
        wr(ADR_TB_CNT, 16'h004D);
        far.pulse_up();
        settle();
      end
      check(16'(irq_cnt[0] - base), ROWS[r].irqs);
      check({15'h0000, pin_o[0]}, ROWS[r].pin);
      check({15'h0000, oe_o[0]}, ROWS[r].oe);
    end
    rd(ADR_TB_CNT, d);
    check(d, 16'h004E);
    // mode 3 pin falls at overflow, timer reloads
    wr({BANK_CTL, 4'h0}, 16'h000E);
    wr(ADR_TA_REL, 16'h0100);
    wr(ADR_TA_CNT, 16'hFFFF);
    far.pulse_up();
    settle();
    check({15'h0000, pin_o[0]}, 16'h0000);
    rd(ADR_TA_CNT, d);
    check(d, 16'h0100);
    // partner channel 8 toggles pin 0
    wr({BANK_CTL, 4'h0}, 16'h0046);
    wr({BANK_VAL, 4'h0}, 16'h0055);
    wr({BANK_VAL, 4'h8}, 16'h0050);
    wr({BANK_CTL, 4'h8}, 16'h0006);
    wr(ADR_TA_CNT, 16'h004F);
    far.pulse_up();
    settle();
    check({15'h0000, pin_o[0]}, 16'h0001);
    // capture on rise, fall and both
    for (int e = 1; e < 4; e++)
    begin
      wr({BANK_CTL, 4'h1}, 16'(4 * e + 1));
      wr(ADR_TA_CNT, 16'(16'h1230 + e));
      settle();
      base = irq_cnt[1];
      far.set_pin(1, 1'b1);
      settle();
      far.set_pin(1, 1'b0);
      settle();
      check(16'(irq_cnt[1] - base), (e == 3) ? 16'h0002 : 16'h0001);
      rd({BANK_VAL, 4'h1}, d);
      check(d, 16'(16'h1230 + e));
    end
    // prescaler at full rate, then staggered
    for (int s = 0; s < 2; s++)
    begin
      wr(ADR_TCTL, (s == 1) ? 16'h8020 : 16'h0020);
      rd(ADR_TA_CNT, d);
      repeat (62) @(posedge clk_i);
      rd(ADR_TA_CNT, q);
      check(q - d, (s == 1) ? 16'h0008 : 16'h0040);
    end
    // external count input
    wr(ADR_TCTL, 16'h0030);
    wr(ADR_TA_CNT, 16'h0000);
    repeat (3) far.pulse_ext();
    settle();
    rd(ADR_TA_CNT, d);
    check(d, 16'h0003);
    // reset in mid-run: timers stop, channels off, pins released
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(ADR_TCTL, d);
    check(d, 16'h0000);
    check({6'h00, pin_o}, 16'h0000);
    check({6'h00, oe_o}, 16'h0000);
    rd(ADR_TA_CNT, d);
    check(d, 16'h0000);
    rd({BANK_VAL, 4'h1}, d);
    check(d, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
